// ### rtl/special_status_area_params.svh
// Purpose : Constants for the special status and control word area
// Assumes : Word-addressed area, one 32-bit bus word per area word
// Notes   : Indices are area word numbers; byte address is four times
`ifndef SPECIAL_STATUS_AREA_PARAMS_SVH
`define SPECIAL_STATUS_AREA_PARAMS_SVH

// *********************************************************************
// Area geometry
// *********************************************************************
`define SSA_FIRST_WORD    10'd236
`define SSA_LAST_WORD     10'd299
`define SSA_SPLIT_WORD    10'd256
`define SSA_WORDS         64
`define SSA_BIT_FIRST     15'd23600
`define SSA_BIT_LAST      15'd29915
`define SSA_RESET_WORD    16'h0000

// *********************************************************************
// Word indices
// *********************************************************************
`define IDX_NODE_LOOP     10'h0ec
`define IDX_COMPLETION    10'h0ed
`define IDX_LINK_LVL0     10'h0ee
`define IDX_LINK_LVL1     10'h0f2
`define IDX_UNUSED        10'h0f6
`define IDX_UPPER_FLAGS   10'h0f7
`define IDX_LOWER_FLAGS   10'h0f9
`define IDX_RIO_ERROR     10'h0fb
`define IDX_CONTROL       10'h0fc

// *********************************************************************
// Field positions and masks
// *********************************************************************
`define RIO_READ_BIT      0
`define RIO_FLAG_BIT      3
`define RIO_UNIT_LSB      4
`define RIO_MASTER_LSB    8
`define RIO_WR_MASK       16'h0001
`define RIO_RSVD_MASK     16'h0086
`define CTRL_WR_MASK      16'hbf80
`define CTRL_RSVD_MASK    16'h4000
`define RESTART_BITS      16'h2380
`define CONTROL_BITS      16'h9c00

// *********************************************************************
// Timing
// *********************************************************************
`define WAIT_SECTION1     2'd0
`define WAIT_SECTION2     2'd1

// *********************************************************************
// Bus responses
// *********************************************************************
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// ### rtl/special_status_area_pkg.sv
// Purpose : Types for the special status and control word area
// Assumes : Constants come from the params header
// Notes   : Module state other than the reset and bit query flops lives in one packed struct
package special_status_area_pkg;

   typedef enum logic [1:0] {
      WR_IDLE = 2'b00,
      WR_WAIT = 2'b01,
      WR_RESP = 2'b10
   } wr_state_e;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_WAIT = 2'b01,
      RD_RESP = 2'b10
   } rd_state_e;

   typedef struct packed {
      logic [63:0][15:0] mem;
      wr_state_e         wrState;
      logic              awHave;
      logic              wHave;
      logic [5:0]        wrIdx;
      logic              wrOk;
      logic [15:0]       wrData;
      logic [1:0]        wrStrb;
      logic [1:0]        wrCnt;
      logic [1:0]        bresp;
      rd_state_e         rdState;
      logic [5:0]        rdIdx;
      logic              rdOk;
      logic [1:0]        rdCnt;
      logic [15:0]       rdData;
      logic [1:0]        rresp;
      logic [3:0]        restartPulse;
      logic              bitValue;
   } ssa_state_s;

endpackage

// ### rtl/special_status_area.sv
// Purpose : Special status and control word area behind AXI4-Lite
// Assumes : Device status ports are on clk_sys; bit query is sampled
// Notes   : Word w sits at byte address 4*w
//
// Functional notes
// - Area spans words 236 to 299, sixteen bits per word.
// - Bits addressed as word number then two-digit bit, 23600 to 29915.
// - Split between words 255 and 256; no word access spans it.
// - Accesses to the second section take longer than to the first.
// - Status flags read OFF until their condition, then turn ON.
// - Restart bits rest OFF; ON then OFF restarts that link unit.
// - Other control bits stay OFF until software sets them.
// - Only certain words and bits accept software writes.
// - Word 236 holds node loop status, level 0 low, level 1 high.
// - Word 237 holds completion code, level 0 low, level 1 high.
// - Words 238 to 241 hold level 0 data link status, all bits.
// - Words 242 to 245 hold level 1 data link status, all bits.
// - Words 247, 248 hold upper unit run and error flags.
// - Words 249, 250 hold lower unit run and error flags.
// - Bit 03 of word 251 turns ON on a remote I/O error.
// - Bits 04 to 06 of 251 give failing rack and unit number.
// - Bits 08 to 15 of 251 give master unit and allocated word.
`timescale 1ns/10ps
`include "special_status_area_params.svh"

module special_status_area
   import special_status_area_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        clkEn,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        devWrEn,
   input  wire logic [5:0]  devWrWord,
   input  wire logic [15:0] devWrData,
   input  wire logic [15:0] devWrMask,
   input  wire logic        rioErrEvent,
   input  wire logic [2:0]  rioErrUnit,
   input  wire logic [7:0]  rioErrMaster,
   input  wire logic [14:0] bitQueryNum,
   output logic             bitQueryValue,
   output logic             rioErrReadReq,
   output logic [3:0]       linkRestart,
   output logic [3:0]       controlBits
);

   // ******************************************************************
   // Reset release
   // ******************************************************************
   logic       rstSync1_q;
   logic       rstSync2_q;
   logic       rstN;
   logic [14:0] bitQuerySync1_q;
   logic [14:0] bitQuerySync2_q;
   logic [14:0] bitQuerySync3_q;
   logic [14:0] bitQueryHeld_q;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rstSync1_q <= 1'b0;
         rstSync2_q <= 1'b0;
      end else begin
         rstSync1_q <= 1'b1;
         rstSync2_q <= rstSync1_q;
      end
   end

   assign rstN = rstSync2_q;

   // ******************************************************************
   // Bit query input
   // ******************************************************************
   // Query number comes from outside the clock domain
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         bitQuerySync1_q <= 15'h0000;
         bitQuerySync2_q <= 15'h0000;
         bitQuerySync3_q <= 15'h0000;
         bitQueryHeld_q  <= 15'h0000;
      end else if (clkEn) begin
         bitQuerySync1_q <= bitQueryNum;
         bitQuerySync2_q <= bitQuerySync1_q;
         bitQuerySync3_q <= bitQuerySync2_q;
         // Bits may land in different cycles; take two equal samples
         if (bitQuerySync2_q == bitQuerySync3_q) begin
            bitQueryHeld_q <= bitQuerySync2_q;
         end
      end
   end

   // ******************************************************************
   // Helpers
   // ******************************************************************
   function automatic logic addrMapped(input logic [31:0] a);
      addrMapped = (a[31:12] == 20'h00000) && (a[1:0] == 2'b00) &&
                   (a[11:2] >= `SSA_FIRST_WORD) &&
                   (a[11:2] <= `SSA_LAST_WORD);
   endfunction

   function automatic logic [5:0] addrIdx(input logic [31:0] a);
      logic [9:0] diff;
      diff = a[11:2] - `SSA_FIRST_WORD;
      addrIdx = diff[5:0];
   endfunction

   function automatic logic [5:0] wordIdx(input logic [9:0] w);
      logic [9:0] diff;
      diff = w - `SSA_FIRST_WORD;
      wordIdx = diff[5:0];
   endfunction

   function automatic logic [1:0] sectionWait(input logic [5:0] idx);
      sectionWait = ({4'h0, idx} >= wordIdx(`SSA_SPLIT_WORD)) ?
                    `WAIT_SECTION2 : `WAIT_SECTION1;
   endfunction

   // Keep bits outside the mask, take new ones inside it
   function automatic logic [15:0] mergeBits(input logic [15:0] old,
                                             input logic [15:0] fresh,
                                             input logic [15:0] m);
      mergeBits = (old & ~m) | (fresh & m);
   endfunction

   // Byte lanes of the low half word
   function automatic logic [15:0] laneMask(input logic [1:0] strb);
      laneMask = {{8{strb[1]}}, {8{strb[0]}}};
   endfunction

   // Bits software may change
   function automatic logic [15:0] wrMask(input logic [5:0] idx);
      if (idx == wordIdx(`IDX_RIO_ERROR)) begin
         wrMask = `RIO_WR_MASK;
      end else if (idx == wordIdx(`IDX_CONTROL)) begin
         wrMask = `CTRL_WR_MASK;
      end else begin
         wrMask = 16'h0000;
      end
   endfunction

   // Bits kept at zero for ever
   function automatic logic [15:0] rsvdMask(input logic [5:0] idx);
      if (idx == wordIdx(`IDX_UNUSED)) begin
         rsvdMask = 16'hffff;
      end else if (idx == wordIdx(`IDX_RIO_ERROR)) begin
         rsvdMask = `RIO_RSVD_MASK;
      end else if (idx == wordIdx(`IDX_CONTROL)) begin
         rsvdMask = `CTRL_RSVD_MASK;
      end else begin
         rsvdMask = 16'h0000;
      end
   endfunction

   // ******************************************************************
   // State
   // ******************************************************************
   ssa_state_s q;
   ssa_state_s d;

   logic [15:0] swMask;
   logic [15:0] devMask;
   logic [15:0] ctrlOld;
   logic [15:0] ctrlNew;
   logic [15:0] restartFall;
   logic [9:0]  qWord;
   logic [6:0]  qBit;
   logic [9:0]  qWordLim;
   logic [5:0]  qIdx;
   logic [5:0]  rioIdx;

   always_comb begin
      d = q;
      swMask = 16'h0000;
      devMask = 16'h0000;
      rioIdx = wordIdx(`IDX_RIO_ERROR);

      // Write channel
      case (q.wrState)
         WR_IDLE: begin
            if (s_axi_awvalid && !q.awHave) begin
               d.awHave = 1'b1;
               d.wrOk = addrMapped(s_axi_awaddr);
               d.wrIdx = addrIdx(s_axi_awaddr);
            end
            if (s_axi_wvalid && !q.wHave) begin
               d.wHave = 1'b1;
               d.wrData = s_axi_wdata[15:0];
               d.wrStrb = s_axi_wstrb[1:0];
            end
            if (q.awHave && q.wHave) begin
               d.wrCnt = sectionWait(q.wrIdx);
               d.wrState = WR_WAIT;
            end
         end
         WR_WAIT: begin
            if (q.wrCnt == 2'd0) begin
               if (q.wrOk) begin
                  // One bus word is one area word, never two
                  swMask = wrMask(q.wrIdx) & laneMask(q.wrStrb);
                  d.mem[q.wrIdx] = mergeBits(q.mem[q.wrIdx], q.wrData,
                                             swMask);
               end
               d.bresp = q.wrOk ? `RESP_OKAY : `RESP_SLVERR;
               d.wrState = WR_RESP;
            end else begin
               d.wrCnt = q.wrCnt - 2'd1;
            end
         end
         WR_RESP: begin
            if (s_axi_bready) begin
               d.awHave = 1'b0;
               d.wHave = 1'b0;
               d.wrState = WR_IDLE;
            end
         end
         default: begin
            d.wrState = WR_IDLE;
         end
      endcase

      // Device status updates skip software-writable and reserved bits
      if (devWrEn) begin
         devMask = devWrMask & ~wrMask(devWrWord) &
                   ~rsvdMask(devWrWord);
         d.mem[devWrWord] = mergeBits(d.mem[devWrWord], devWrData,
                                      devMask);
      end
      if (rioErrEvent) begin
         d.mem[rioIdx][`RIO_FLAG_BIT] = 1'b1;
         d.mem[rioIdx][`RIO_UNIT_LSB +: 3] = rioErrUnit;
         d.mem[rioIdx][`RIO_MASTER_LSB +: 8] = rioErrMaster;
      end

      // Restart on ON then OFF
      ctrlOld = q.mem[wordIdx(`IDX_CONTROL)];
      ctrlNew = d.mem[wordIdx(`IDX_CONTROL)];
      restartFall = ctrlOld & ~ctrlNew & `RESTART_BITS;
      d.restartPulse = {restartFall[13], restartFall[9],
                        restartFall[8], restartFall[7]};

      // Read channel
      case (q.rdState)
         RD_IDLE: begin
            if (s_axi_arvalid) begin
               d.rdOk = addrMapped(s_axi_araddr);
               d.rdIdx = addrIdx(s_axi_araddr);
               d.rdCnt = sectionWait(addrIdx(s_axi_araddr));
               d.rdState = RD_WAIT;
            end
         end
         RD_WAIT: begin
            if (q.rdCnt == 2'd0) begin
               d.rdData = q.rdOk ? q.mem[q.rdIdx] : 16'h0000;
               d.rresp = q.rdOk ? `RESP_OKAY : `RESP_SLVERR;
               d.rdState = RD_RESP;
            end else begin
               d.rdCnt = q.rdCnt - 2'd1;
            end
         end
         RD_RESP: begin
            if (s_axi_rready) begin
               d.rdState = RD_IDLE;
            end
         end
         default: begin
            d.rdState = RD_IDLE;
         end
      endcase

      // Bit query by combined number
      qWordLim = 10'(bitQueryHeld_q / 15'd100);
      qBit = 7'(bitQueryHeld_q % 15'd100);
      qWord = qWordLim;
      qIdx = wordIdx(qWord);
      if ((bitQueryHeld_q >= `SSA_BIT_FIRST) &&
          (bitQueryHeld_q <= `SSA_BIT_LAST) && (qBit < 7'd16)) begin
         d.bitValue = q.mem[qIdx][qBit[3:0]];
      end else begin
         d.bitValue = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         q.mem <= {`SSA_WORDS{`SSA_RESET_WORD}};
         q.wrState <= WR_IDLE;
         q.awHave <= 1'b0;
         q.wHave <= 1'b0;
         q.wrIdx <= 6'h00;
         q.wrOk <= 1'b0;
         q.wrData <= 16'h0000;
         q.wrStrb <= 2'h0;
         q.wrCnt <= 2'h0;
         q.bresp <= 2'h0;
         q.rdState <= RD_IDLE;
         q.rdIdx <= 6'h00;
         q.rdOk <= 1'b0;
         q.rdCnt <= 2'h0;
         q.rdData <= 16'h0000;
         q.rresp <= 2'h0;
         q.restartPulse <= 4'h0;
         q.bitValue <= 1'b0;
      end else if (clkEn) begin
         q <= d;
      end
   end

   // ******************************************************************
   // Outputs
   // ******************************************************************
   assign s_axi_awready = (q.wrState == WR_IDLE) && !q.awHave;
   assign s_axi_wready  = (q.wrState == WR_IDLE) && !q.wHave;
   assign s_axi_bvalid  = (q.wrState == WR_RESP);
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = (q.rdState == RD_IDLE);
   assign s_axi_rvalid  = (q.rdState == RD_RESP);
   assign s_axi_rresp   = q.rresp;
   assign s_axi_rdata   = {16'h0000, q.rdData};
   assign bitQueryValue = q.bitValue;
   assign rioErrReadReq = q.mem[wordIdx(`IDX_RIO_ERROR)][`RIO_READ_BIT];
   assign linkRestart   = q.restartPulse;
   assign controlBits   = {q.mem[wordIdx(`IDX_CONTROL)][15],
                           q.mem[wordIdx(`IDX_CONTROL)][12:10]};

endmodule

// ### verif/special_status_area_asserts.sv
// Purpose : Port-level checks for the special status word area
// Assumes : clkEn held high by the bench
// Notes   : Sees only top-level ports
`timescale 1ns/10ps
module special_status_area_asserts (
   input wire logic        clk_sys,
   input wire logic        rst_b,
   input wire logic [31:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [14:0] bitQueryNum,
   input wire logic        bitQueryValue,
   input wire logic [3:0]  linkRestart,
   input wire logic [3:0]  controlBits
);
   // ***********
   // Checks
   // ***********
   logic arHs, inMap, sec2, qOut;
   assign arHs  = s_axi_arvalid && s_axi_arready;
   assign sec2  = s_axi_araddr[31:2] >= 30'd256;
   assign inMap = s_axi_araddr[1:0] == 2'b00 &&
                  s_axi_araddr[31:2] >= 30'd236 &&
                  s_axi_araddr[31:2] <= 30'd299;
   assign qOut  = bitQueryNum < 15'd23600 || bitQueryNum > 15'd29915;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   a_read_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response not held");
   a_write_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response not held");
   a_sec1_read: assert property (
      arHs && inMap && !sec2 |=> !s_axi_rvalid ##1 s_axi_rvalid)
      else $error("first section read latency wrong");
   a_sec2_read: assert property (
      arHs && inMap && sec2 |=> !s_axi_rvalid [*2] ##1 s_axi_rvalid)
      else $error("second section read latency wrong");
   a_unmapped_read: assert property (
      arHs && !inMap |-> ##[2:3] s_axi_rvalid && s_axi_rresp == 2'b10 &&
      s_axi_rdata == 32'h0) else $error("unmapped read not refused");
   a_restart_pulse: assert property (
      linkRestart != 4'h0 |=> linkRestart == 4'h0)
      else $error("restart pulse too long");
   a_ctrl_quiet: assert property (
      $changed(controlBits) |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("control bits moved without a write");
   a_query_range: assert property (
      qOut [*5] |-> !bitQueryValue)
      else $error("out of range bit query not zero");
   cover property (arHs && inMap && sec2);
   cover property (linkRestart != 4'h0);
   cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule

// ### verif/link_model.sv
// Purpose : Link unit and remote master stand-in driving device status
// Assumes : Same clock as the status area
// Notes   : Idle lines show inverted data so stale values never pass
`timescale 1ns/10ps
module link_model (
   input  wire logic  clk_sys,
   output logic       devWrEn,
   output logic [5:0] devWrWord,
   output logic [15:0] devWrData,
   output logic [15:0] devWrMask,
   output logic       rioErrEvent,
   output logic [2:0] rioErrUnit,
   output logic [7:0] rioErrMaster
);
   // ***********
   // Model
   // ***********
   initial begin
      devWrEn = 1'b0;
      rioErrEvent = 1'b0;
   end
   // Status word update after an idle gap
   task automatic putWord(input logic [5:0] w, input logic [15:0] d,
                          input logic [15:0] m, input int gap);
      repeat (gap + 1) @(posedge clk_sys);
      devWrEn <= 1'b1;
      devWrWord <= w;
      devWrData <= d;
      devWrMask <= m;
      @(posedge clk_sys);
      devWrEn <= 1'b0;
      devWrWord <= ~w;
      devWrData <= ~d;
      devWrMask <= ~m;
   endtask
   // Remote error report with rack, unit and master
   task automatic rioError(input logic [2:0] u, input logic [7:0] m);
      @(posedge clk_sys);
      rioErrEvent <= 1'b1;
      rioErrUnit <= u;
      rioErrMaster <= m;
      @(posedge clk_sys);
      rioErrEvent <= 1'b0;
      rioErrUnit <= ~u;
      rioErrMaster <= ~m;
   endtask
endmodule

// ### verif/special_status_area_tb.sv
// Purpose : Self-checking bench for the special status word area
// Assumes : clkEn held high; device status from the link model
// Notes   : Bus handshakes judged at the falling edge before each rise
`timescale 1ns/10ps
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin errCount++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module special_status_area_tb;
   logic        clk_sys, rst_b, clkEn, devWrEn, rioErrEvent;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0]  s_axi_wstrb, linkRestart, controlBits, tog;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, bitQueryValue, rioErrReadReq;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic [5:0]  devWrWord;
   logic [15:0] devWrData, devWrMask, rd;
   logic [2:0]  rioErrUnit;
   logic [7:0]  rioErrMaster;
   logic [14:0] bitQueryNum;
   int          errCount, nChecks, cyc, lat, lat1;
   localparam int RB[4] = '{7, 8, 9, 13};
   special_status_area u_special_status_area (.clk_sys, .rst_b, .clkEn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .devWrEn, .devWrWord, .devWrData, .devWrMask,
      .rioErrEvent, .rioErrUnit, .rioErrMaster, .bitQueryNum,
      .bitQueryValue, .rioErrReadReq, .linkRestart, .controlBits);
   link_model u_link_model (.clk_sys, .devWrEn, .devWrWord, .devWrData,
      .devWrMask, .rioErrEvent, .rioErrUnit, .rioErrMaster);
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      tog <= tog ^ linkRestart;
      cyc++;
      if (cyc == 20000) begin
         errCount++;
         end_of_test;
      end
   end
   // ***********
   // Bus tasks
   // ***********
   function automatic logic [31:0] ad(input int w);
      return 32'(w) << 2;
   endfunction
   function automatic logic [15:0] pat(input int w);
      return 16'(w * 257) ^ 16'h5a3c;
   endfunction
   task automatic axiW(input logic [31:0] a, input logic [15:0] d,
                       output logic [1:0] r);
      logic aw, wh, bh;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'hffff, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge clk_sys);
         aw = s_axi_awvalid & s_axi_awready;
         wh = s_axi_wvalid & s_axi_wready;
         bh = s_axi_bvalid & s_axi_bready;
         r = s_axi_bresp;
         @(posedge clk_sys);
         if (aw) s_axi_awvalid <= 1'b0;
         if (wh) s_axi_wvalid <= 1'b0;
      end while (!bh);
      s_axi_bready <= 1'b0;
   endtask
   task automatic axiR(input logic [31:0] a, output logic [15:0] d,
                       output logic [1:0] r);
      logic ah, rh;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      lat = 0;
      do begin
         @(negedge clk_sys);
         ah = s_axi_arvalid & s_axi_arready;
         rh = s_axi_rvalid & s_axi_rready;
         d = s_axi_rdata[15:0];
         r = s_axi_rresp;
         lat++;
         @(posedge clk_sys);
         if (ah) s_axi_arvalid <= 1'b0;
      end while (!rh);
      s_axi_rready <= 1'b0;
   endtask
   task automatic rdChk(input int w, input logic [15:0] e);
      axiR(ad(w), rd, rs);
      `CHK(rd, e)
      `CHK(rs, 2'b00)
   endtask
   task automatic q(input logic [14:0] n, input logic e);
      @(posedge clk_sys);
      bitQueryNum <= n;
      repeat (6) @(negedge clk_sys);
      `CHK(bitQueryValue, e)
   endtask
   // ***********
   // Scenarios
   // ***********
   task s_device;
      for (int w = 236; w <= 250; w++) begin
         u_link_model.putWord(6'(w - 236), pat(w), 16'hffff, w % 3);
         rdChk(w, (w == 246) ? 16'h0000 : pat(w));
      end
      u_link_model.putWord(6'd19, 16'hff80, 16'h00ff, 0);
      u_link_model.putWord(6'd20, 16'h0001, 16'hffff, 0);
      u_link_model.putWord(6'd63, 16'hbeef, 16'hffff, 1);
      rdChk(299, 16'hbeef);
      q(15'd25507, 1'b1);
      q(15'd25600, 1'b1);
      q(15'd25508, 1'b0);
      axiR(ad(255), rd, rs);
      lat1 = lat;
      `CHK(rd, 16'h0080)
      axiR(ad(256), rd, rs);
      `CHK(lat - lat1, 1)
   endtask
   task s_rio;
      u_link_model.rioError(3'h5, 8'ha7);
      rdChk(251, 16'ha758);
      q(15'd25103, 1'b1);
      q(15'd25116, 1'b0);
      axiW(ad(251), 16'hffff, rs);
      `CHK(rs, 2'b00)
      rdChk(251, 16'ha759);
      `CHK(rioErrReadReq, 1'b1)
      u_link_model.putWord(6'd15, 16'h0000, 16'hffff, 2);
      rdChk(251, 16'h0001);
      axiW(ad(236), 16'h0000, rs);
      rdChk(236, pat(236));
      axiW(ad(251), 16'h0000, rs);
      @(negedge clk_sys);
      `CHK(rioErrReadReq, 1'b0)
   endtask
   task s_restart;
      logic [3:0] t0;
      for (int i = 0; i < 4; i++) begin
         t0 = tog;
         axiW(ad(252), 16'(1 << RB[i]), rs);
         repeat (3) @(negedge clk_sys);
         `CHK(tog ^ t0, 4'h0)
         axiW(ad(252), 16'h0000, rs);
         repeat (3) @(negedge clk_sys);
         `CHK(tog ^ t0, 4'(1 << i))
      end
      axiW(ad(252), 16'hffff, rs);
      rdChk(252, 16'hbf80);
      `CHK(controlBits, 4'hf)
      t0 = tog;
      s_axi_wstrb <= 4'h2;
      axiW(ad(252), 16'h0000, rs);
      s_axi_wstrb <= 4'h3;
      repeat (3) @(negedge clk_sys);
      `CHK(tog ^ t0, 4'he)
      rdChk(252, 16'h0080);
      `CHK(controlBits, 4'h0)
   endtask
   task s_unmapped;
      axiW(ad(300), 16'h1234, rs);
      `CHK(rs, 2'b10)
      axiW(ad(236) + 2, 16'h1234, rs);
      `CHK(rs, 2'b10)
      axiR(ad(235), rd, rs);
      `CHK(rs, 2'b10)
      `CHK(rd, 16'h0000)
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", nChecks, errCount);
      if (errCount == 0 && nChecks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, errCount, nChecks, cyc} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, tog} = '0;
      clkEn = 1'b1;
      s_axi_wstrb = 4'h3;
      bitQueryNum = 15'd0;
      repeat (12) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk_sys);
      for (int w = 236; w <= 299; w++) rdChk(w, 16'h0000);
      `CHK(controlBits, 4'h0)
      s_device;
      s_rio;
      s_restart;
      s_unmapped;
      end_of_test;
   end
endmodule
bind special_status_area special_status_area_asserts
   u_special_status_area_asserts (.clk_sys, .rst_b, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .bitQueryNum, .bitQueryValue, .linkRestart,
   .controlBits);
